// >>> common/adc_readout_defs.svh
// timing, width and sync constants for the dual converter readout host
// What this block does
// - strobe stays high while sampling; its falling edge starts a conversion
// - no shifting until at least 220 ns after the strobe falls
// - cycle is strobe-high plus conversion plus readout, 500 ns to 1000000 ns
// - shift clock activity ends no later than the strobe's next rise
// - shift clock period at least 15.6 ns, high and low at least 7 ns
// - slow use may capture on own shift clock; echo negative tied high in single-ended mode (code ties it high only with own-clock capture)
// - differential mode uses pairs; host drives shift clock as a pair
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH

`define CLK_PERIOD_NS      8
`define STROBE_HIGH_NS     25
`define CONVERSION_NS      220
`define CYCLE_MIN_NS       500
`define CYCLE_MAX_NS       1000000
`define SHIFT_PHASE_MIN_NS 7
`define SHIFT_PERIOD_MIN_PS 15600
`define CEIL_CYCLES(ns)    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOOR_CYCLES(ns)   ((ns) / `CLK_PERIOD_NS)

`define STROBE_HIGH_CYCLES `CEIL_CYCLES(`STROBE_HIGH_NS)
`define CONVERSION_CYCLES  `CEIL_CYCLES(`CONVERSION_NS)
`define CYCLE_MIN_CYCLES   `CEIL_CYCLES(`CYCLE_MIN_NS)
`define CYCLE_MAX_CYCLES   `FLOOR_CYCLES(`CYCLE_MAX_NS)
`define SHIFT_HALF_MIN     `CEIL_CYCLES(`SHIFT_PHASE_MIN_NS)

`define WORD_BITS          16
`define BIT_COUNT_W        5
`define PHASE_W            9
`define CYCLE_W            17
`define LAST_BIT_INDEX     4'hF
`define ECHO_WAIT_CYCLES   32
`define FIFO_DEPTH_WORDS   8

`endif

// >>> common/adc_readout_pkg.sv
// types shared by the readout host
package adc_readout_pkg;

  // lane signalling as set by the converter's three-state strap
  typedef enum logic [1:0] {
    SINGLE_ENDED,
    DIFFERENTIAL,
    LOW_POWER_DIFFERENTIAL
  } lane_mode_type;

  // host sequencing through one conversion cycle
  typedef enum logic [2:0] {
    IDLE,
    STROBE_HIGH,
    CONVERTING,
    SHIFTING,
    WAIT_WORD,
    GAP
  } host_state_type;

endpackage

// >>> design/adc_readout_host.sv
// host controller that converts, reads out and buffers both converter channels
`timescale 1ns/1ns
`include "adc_readout_defs.svh"

// ****************************************************************
// result buffer with registered output stage
// ****************************************************************
module result_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `FIFO_DEPTH_WORDS
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  // the output register counts as a slot of its own, so depth plus one words fit
  assign in_ready = (count != PTR_W'(0) + (PTR_W+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (count != '0) && (!out_valid || out_ready);

  // storage array, written only at the write pointer
  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  // output stage holds its word until the drain side takes it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= store[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ****************************************************************
// readout host top
// ****************************************************************
module adc_readout_host
  import adc_readout_pkg::*;
#(
  parameter int CYCLE_CYCLES      = `CYCLE_MIN_CYCLES,
  parameter int CYCLE_MAX_LIMIT   = `CYCLE_MAX_CYCLES,
  parameter int SHIFT_HALF_CYCLES = 4,
  parameter int FIFO_DEPTH        = `FIFO_DEPTH_WORDS
) (
  // system clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // echo clock returned by the converter
  input  wire logic          echo_clock_in,
  // control
  input  wire logic          run,
  input  wire logic          capture_on_own_clock,
  input  wire lane_mode_type lane_mode,
  // converter pins
  output logic               convert_strobe,
  output logic               shift_clock_pos,
  output logic               shift_clock_neg,
  output logic               echo_disable_tie,
  input  wire logic          lane_one_serial_out,
  input  wire logic          lane_two_serial_out,
  // result stream
  output logic               result_valid,
  input  wire logic          result_ready,
  output logic [15:0]        result_lane_one,
  output logic [15:0]        result_lane_two,
  // status
  output logic               frame_active,
  output logic               frame_lost
);
  // the cycle may not exceed the longest the converter allows
  localparam int CYCLE_LEN  = (CYCLE_CYCLES > CYCLE_MAX_LIMIT) ? CYCLE_MAX_LIMIT : CYCLE_CYCLES;
  localparam int HALF_LEN   = (SHIFT_HALF_CYCLES < `SHIFT_HALF_MIN) ? `SHIFT_HALF_MIN : SHIFT_HALF_CYCLES;
  localparam int GAP_TARGET = CYCLE_LEN - `STROBE_HIGH_CYCLES;
  localparam int WORD_W     = 2 * `WORD_BITS;

  // ****************************************************************
  // echo clock domain: capture on echo rising edges
  // ****************************************************************
  logic [`WORD_BITS-1:0] echo_shift_one;
  logic [`WORD_BITS-1:0] echo_shift_two;
  logic [WORD_W-1:0]     echo_hold;
  logic [3:0]            echo_bit;
  logic                  echo_toggle;

  // the echo clock only runs inside a frame, so the word is closed on its own 16th edge
  always_ff @(posedge echo_clock_in or posedge reset) begin
    if (reset) begin
      echo_shift_one <= '0;
      echo_shift_two <= '0;
      echo_hold      <= '0;
      echo_bit       <= '0;
      echo_toggle    <= 1'b0;
    end else begin
      echo_shift_one <= {echo_shift_one[`WORD_BITS-2:0], lane_one_serial_out};
      echo_shift_two <= {echo_shift_two[`WORD_BITS-2:0], lane_two_serial_out};
      echo_bit       <= echo_bit + 1'b1;
      if (echo_bit == `LAST_BIT_INDEX) begin
        echo_hold   <= {echo_shift_one[`WORD_BITS-2:0], lane_one_serial_out,
                        echo_shift_two[`WORD_BITS-2:0], lane_two_serial_out};
        echo_toggle <= ~echo_toggle;
      end
    end
  end

  // ****************************************************************
  // crossings into the system domain
  // ****************************************************************
  logic [2:0] toggle_sync;
  logic       toggle_seen;
  logic       echo_word_event;
  logic [1:0] lane_meta;
  logic [1:0] lane_mid;
  logic [1:0] lane_last;
  logic [1:0] lane_stable;

  // toggle passes three flops; an event counts once the second and third agree
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      toggle_sync <= '0;
      toggle_seen <= 1'b0;
    end else begin
      toggle_sync <= {toggle_sync[1:0], echo_toggle};
      if (toggle_sync[1] == toggle_sync[2]) begin
        toggle_seen <= toggle_sync[2];
      end
    end
  end

  // the hold word stays still for a whole cycle after the toggle, so it is read directly
  assign echo_word_event = (toggle_sync[1] == toggle_sync[2]) && (toggle_sync[2] != toggle_seen);

  // lane pins for own-clock capture, same three-flop agreement
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lane_meta   <= '0;
      lane_mid    <= '0;
      lane_last   <= '0;
      lane_stable <= '0;
    end else begin
      lane_meta <= {lane_one_serial_out, lane_two_serial_out};
      lane_mid  <= lane_meta;
      lane_last <= lane_mid;
      for (int i = 0; i < 2; i++) begin
        if (lane_mid[i] == lane_last[i]) begin
          lane_stable[i] <= lane_last[i];
        end
      end
    end
  end

  // ****************************************************************
  // system domain sequencer
  // ****************************************************************
  host_state_type         state;
  logic [`PHASE_W-1:0]    phase;
  logic [`BIT_COUNT_W-1:0] falls;
  logic [`CYCLE_W-1:0]    cycle_count;
  logic                   own_clock_frame;
  logic [`WORD_BITS-1:0]  own_one;
  logic [`WORD_BITS-1:0]  own_two;
  logic                   push_valid;
  logic [WORD_W-1:0]      push_data;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [WORD_W-1:0]      fifo_out_data;
  logic                   half_done;
  logic                   word_done;
  logic                   echo_word_pending;

  assign half_done = (phase == `PHASE_W'(HALF_LEN - 1));
  // own-clock words are complete once the shifting ends; echo words once the toggle has landed
  assign word_done = own_clock_frame || echo_word_pending;

  // the echo word lands while the last bit is still shifting, so it is kept until the frame ends
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      echo_word_pending <= 1'b0;
    end else if (echo_word_event) begin
      echo_word_pending <= 1'b1;
    end else if (state == IDLE) begin
      echo_word_pending <= 1'b0;
    end
  end

  // cycle timer restarts on every strobe falling edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cycle_count <= '0;
    end else if (state == STROBE_HIGH && phase == `PHASE_W'(`STROBE_HIGH_CYCLES - 1)) begin
      cycle_count <= '0;
    end else if (cycle_count != '1) begin
      cycle_count <= cycle_count + 1'b1;
    end
  end

  // state, phase count and fall count
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state           <= IDLE;
      phase           <= '0;
      falls           <= '0;
      own_clock_frame <= 1'b0;
    end else begin
      phase <= phase + 1'b1;
      case (state)
        IDLE: begin
          phase <= '0;
          // no new conversion unless the buffer can take its result
          if (run && fifo_in_ready) begin
            state           <= STROBE_HIGH;
            own_clock_frame <= capture_on_own_clock;
          end
        end
        STROBE_HIGH: begin
          if (phase == `PHASE_W'(`STROBE_HIGH_CYCLES - 1)) begin
            state <= CONVERTING;
            phase <= '0;
          end
        end
        CONVERTING: begin
          if (phase == `PHASE_W'(`CONVERSION_CYCLES - 1)) begin
            state <= SHIFTING;
            phase <= '0;
            falls <= '0;
          end
        end
        SHIFTING: begin
          if (half_done) begin
            phase <= '0;
            if (shift_clock_pos) begin
              falls <= falls + 1'b1;
              if (falls == `BIT_COUNT_W'(`WORD_BITS - 1)) begin
                state <= WAIT_WORD;
              end
            end
          end
        end
        WAIT_WORD: begin
          // a lost echo clock must not hang the sequencer
          if (word_done || phase == `PHASE_W'(`ECHO_WAIT_CYCLES - 1)) begin
            state <= GAP;
          end
        end
        GAP: begin
          if (cycle_count >= `CYCLE_W'(GAP_TARGET - 1)) begin
            state <= IDLE;
          end
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // convert strobe: high except from conversion start to the end of the cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      convert_strobe <= 1'b1;
    end else if (state == STROBE_HIGH && phase == `PHASE_W'(`STROBE_HIGH_CYCLES - 1)) begin
      convert_strobe <= 1'b0;
    end else if (state == GAP && cycle_count >= `CYCLE_W'(GAP_TARGET - 1)) begin
      convert_strobe <= 1'b1;
    end
  end

  // positive shift pin idles low, negative pin high in the differential modes; the clock toggles every half period while shifting only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift_clock_pos <= 1'b0;
      shift_clock_neg <= 1'b0;
    end else begin
      if (state == SHIFTING && half_done) begin
        shift_clock_pos <= ~shift_clock_pos;
        // the negative leg only toggles as a pair in the differential modes
        shift_clock_neg <= (lane_mode != SINGLE_ENDED) ? shift_clock_pos : 1'b0;
      end else if (state != SHIFTING) begin
        shift_clock_pos <= 1'b0;
        shift_clock_neg <= (lane_mode != SINGLE_ENDED);
      end
    end
  end

  // echo negative pin is tied high only for single-ended own-clock capture
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      echo_disable_tie <= 1'b0;
    end else begin
      echo_disable_tie <= capture_on_own_clock && (lane_mode == SINGLE_ENDED);
    end
  end

  // own-clock capture just before each fall; sync delay of four cycles fits the high phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      own_one <= '0;
      own_two <= '0;
    end else if (state == SHIFTING && half_done && shift_clock_pos) begin
      own_one <= {own_one[`WORD_BITS-2:0], lane_stable[1]};
      own_two <= {own_two[`WORD_BITS-2:0], lane_stable[0]};
    end
  end

  // at most one word per frame enters the buffer, none for a lost frame, lane one in the upper half
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      push_valid <= 1'b0;
      push_data  <= '0;
      frame_lost <= 1'b0;
    end else begin
      push_valid <= (state == WAIT_WORD) && word_done;
      push_data  <= own_clock_frame ? {own_one, own_two} : echo_hold;
      frame_lost <= (state == WAIT_WORD) && !word_done
                    && (phase == `PHASE_W'(`ECHO_WAIT_CYCLES - 1));
    end
  end

  // busy flag from conversion start to the end of the gap
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frame_active <= 1'b0;
    end else begin
      frame_active <= (state != IDLE) && (state != STROBE_HIGH);
    end
  end

  // ****************************************************************
  // result buffer
  // ****************************************************************
  result_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_result_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (result_ready),
    .out_data  (fifo_out_data)
  );

  // buffer output stage is already a register, so these stay flop-driven
  assign result_valid    = fifo_out_valid;
  assign result_lane_one = fifo_out_data[WORD_W-1:`WORD_BITS];
  assign result_lane_two = fifo_out_data[`WORD_BITS-1:0];

endmodule

// >>> tb/adc_readout_host_chk.sv
// property checker for the converter readout host
`timescale 1ns/1ns
module adc_readout_host_chk
  import adc_readout_pkg::*;
#(
  parameter int CYCLE_CYCLES      = 63,
  parameter int SHIFT_HALF_CYCLES = 4
) (
  // clock, reset and control
  input wire logic          clk_sys,
  input wire logic          reset,
  input wire logic          capture_on_own_clock,
  input wire lane_mode_type lane_mode,
  // converter pins
  input wire logic          convert_strobe,
  input wire logic          shift_clock_pos,
  input wire logic          shift_clock_neg,
  input wire logic          echo_disable_tie,
  // result stream and status
  input wire logic          result_valid,
  input wire logic          result_ready,
  input wire logic [15:0]   result_lane_one,
  input wire logic [15:0]   result_lane_two,
  input wire logic          frame_active,
  input wire logic          frame_lost
);
  localparam int CONV_CYCLES = 28;
  logic        prev_strobe;
  logic        prev_pos;
  logic [16:0] since_fall;
  logic [7:0]  hold;
  logic [4:0]  falls;
  // ****************************************
  // helper counters and properties
  // ****************************************
  // levels one cycle back, to spot edges
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev_strobe <= 1'b1;
      prev_pos    <= 1'b0;
    end else begin
      prev_strobe <= convert_strobe;
      prev_pos    <= shift_clock_pos;
    end
  end
  // cycles since the strobe fell; saturates so a long idle spell never wraps
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      since_fall <= 17'h1FFFF;
    else if (prev_strobe && !convert_strobe)
      since_fall <= 17'h00001;
    else if (since_fall != 17'h1FFFF)
      since_fall <= since_fall + 17'h00001;
  end
  // length of the current shift clock phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      hold <= 8'h00;
    else if (shift_clock_pos != prev_pos)
      hold <= 8'h01;
    else if (hold != 8'hFF)
      hold <= hold + 8'h01;
  end
  // shift clock falls within the current frame
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      falls <= 5'h00;
    else if (prev_strobe && !convert_strobe)
      falls <= 5'h00;
    else if (prev_pos && !shift_clock_pos)
      falls <= falls + 5'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_strobe_high; $rose(convert_strobe) |-> convert_strobe [*4]; endproperty
  a_strobe_high: assert property (p_strobe_high) else $error("strobe high phase too short");
  property p_conv_wait; $rose(shift_clock_pos) |-> since_fall >= CONV_CYCLES; endproperty
  a_conv_wait: assert property (p_conv_wait) else $error("shifting before conversion ended");
  property p_cycle; $fell(convert_strobe) |-> since_fall >= CYCLE_CYCLES; endproperty
  a_cycle: assert property (p_cycle) else $error("conversion cycle too short");
  property p_quiet; convert_strobe |-> !shift_clock_pos; endproperty
  a_quiet: assert property (p_quiet) else $error("shift clock active while strobe high");
  property p_high_phase; $fell(shift_clock_pos) |-> hold == SHIFT_HALF_CYCLES; endproperty
  a_high_phase: assert property (p_high_phase) else $error("shift high phase wrong");
  property p_low_phase; $rose(shift_clock_pos) && falls != 5'h00 |-> hold == SHIFT_HALF_CYCLES; endproperty
  a_low_phase: assert property (p_low_phase) else $error("shift low phase wrong");
  property p_sixteen; $rose(convert_strobe) |-> falls == 5'h10; endproperty
  a_sixteen: assert property (p_sixteen) else $error("frame did not give sixteen falls");
  property p_neg_pin;
    !$past(reset) && lane_mode == $past(lane_mode) && lane_mode == $past(lane_mode, 2)
      |-> shift_clock_neg == (lane_mode != SINGLE_ENDED && !shift_clock_pos);
  endproperty
  a_neg_pin: assert property (p_neg_pin) else $error("negative shift pin wrong");
  property p_tie;
    frame_active && $past(frame_active)
      |-> echo_disable_tie == (capture_on_own_clock && lane_mode == SINGLE_ENDED);
  endproperty
  a_tie: assert property (p_tie) else $error("echo disable tie wrong");
  property p_lost; frame_lost |=> !frame_lost; endproperty
  a_lost: assert property (p_lost) else $error("lost flag longer than one cycle");
  property p_hold;
    result_valid && !result_ready
      |=> result_valid && $stable(result_lane_one) && $stable(result_lane_two);
  endproperty
  a_hold: assert property (p_hold) else $error("result dropped before taken");
  c_lost: cover property (frame_lost);
  c_full: cover property (result_valid && !result_ready [*8]);
  c_diff: cover property ($rose(shift_clock_pos) && lane_mode != SINGLE_ENDED);
endmodule

bind adc_readout_host adc_readout_host_chk #(
  .CYCLE_CYCLES(CYCLE_CYCLES), .SHIFT_HALF_CYCLES(SHIFT_HALF_CYCLES)
) i_adc_readout_host_chk (
  .clk_sys(clk_sys), .reset(reset), .capture_on_own_clock(capture_on_own_clock),
  .lane_mode(lane_mode), .convert_strobe(convert_strobe), .shift_clock_pos(shift_clock_pos),
  .shift_clock_neg(shift_clock_neg), .echo_disable_tie(echo_disable_tie),
  .result_valid(result_valid), .result_ready(result_ready), .result_lane_one(result_lane_one),
  .result_lane_two(result_lane_two), .frame_active(frame_active), .frame_lost(frame_lost)
);

// >>> tb/adc_device_model.sv
// behavioural model of the dual converter as seen at its pins
`timescale 1ns/1ns
module adc_device_model (
  // pins from the host
  input  wire logic        convert_strobe,
  input  wire logic        shift_clock_pos,
  input  wire logic        echo_disable_tie,
  // bench knobs: words to convert, slow echo, muted echo
  input  wire logic [15:0] word_one,
  input  wire logic [15:0] word_two,
  input  wire logic        slow,
  input  wire logic        mute,
  // pins to the host
  output logic             lane_one_serial_out,
  output logic             lane_two_serial_out,
  output logic             echo_clock_out
);
  logic [15:0] shift_one = 16'h0000;
  logic [15:0] shift_two = 16'h0000;
  logic        driving   = 1'b0;
  logic        echo_fast;
  logic        echo_late;
  // ****************************************
  // conversion and readout
  // ****************************************
  // strobe fall freezes both words; bits appear only once conversion is over
  always @(negedge convert_strobe) begin
    shift_one = word_one;
    shift_two = word_two;
    #220 driving = 1'b1;
  end
  // lanes let go shortly after the strobe rises
  always @(posedge convert_strobe) #3 driving = 1'b0;
  // each falling edge moves both lanes on by one bit, msb first; early edges leave the words unshifted
  always @(negedge shift_clock_pos) begin
    shift_one = driving ? {shift_one[14:0], 1'b0} : shift_one;
    shift_two = driving ? {shift_two[14:0], 1'b0} : shift_two;
  end
  // released lanes show the inverse, never a stale good bit; only positive pins modelled
  assign lane_one_serial_out = driving ? shift_one[15] : ~shift_one[15];
  assign lane_two_serial_out = driving ? shift_two[15] : ~shift_two[15];
  // echo follows the shift clock with a prompt or a slow delay
  assign #2 echo_fast = shift_clock_pos;
  assign #5 echo_late = echo_fast;
  assign echo_clock_out = (echo_disable_tie || mute) ? 1'b0 : (slow ? echo_late : echo_fast);
endmodule

// >>> tb/adc_readout_host_bench.sv
// self-checking bench for the converter readout host
`timescale 1ns/1ns
`include "adc_readout_defs.svh"
module adc_readout_host_bench
  import adc_readout_pkg::*;
;
  logic          clk_sys, reset, run, capture_on_own_clock, result_ready;
  lane_mode_type lane_mode;
  logic          echo_clock_in, lane_one, lane_two, slow, mute, drain;
  logic          convert_strobe, shift_clock_pos, shift_clock_neg, echo_disable_tie;
  logic          result_valid, frame_active, frame_lost;
  logic [15:0]   result_lane_one, result_lane_two, word_one, word_two, seed, rnd;
  logic [31:0]   exp_q[$];
  int            mismatches, check_count, frames, lost_seen, stall_mark;
  // ****************************************
  // harness
  // ****************************************
  adc_readout_host i_adc_readout_host (
    .clk_sys(clk_sys), .reset(reset), .echo_clock_in(echo_clock_in), .run(run),
    .capture_on_own_clock(capture_on_own_clock), .lane_mode(lane_mode),
    .convert_strobe(convert_strobe), .shift_clock_pos(shift_clock_pos), .shift_clock_neg(shift_clock_neg),
    .echo_disable_tie(echo_disable_tie), .lane_one_serial_out(lane_one), .lane_two_serial_out(lane_two),
    .result_valid(result_valid), .result_ready(result_ready), .result_lane_one(result_lane_one),
    .result_lane_two(result_lane_two), .frame_active(frame_active), .frame_lost(frame_lost));
  adc_device_model i_adc_device_model (
    .convert_strobe(convert_strobe), .shift_clock_pos(shift_clock_pos),
    .echo_disable_tie(echo_disable_tie), .word_one(word_one), .word_two(word_two), .slow(slow),
    .mute(mute), .lane_one_serial_out(lane_one), .lane_two_serial_out(lane_two),
    .echo_clock_out(echo_clock_in));
  // 16-bit xorshift, fixed start so every run repeats
  function automatic logic [15:0] next_rand();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction
  // a frame is expected to return both words whole, channel one in the upper half
  function automatic logic [31:0] expect_pair(logic [15:0] a, logic [15:0] b);
    return {a, b};
  endfunction
  task automatic check_val(string what, logic [31:0] expv, logic [31:0] seen);
    check_count++;
    if (seen !== expv) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk_sys) reset = 1'b1;
    exp_q.delete();
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
  endtask
  // n frames, then idle until every word has come back
  task automatic run_frames(int n);
    @(negedge clk_sys) run = 1'b1;
    repeat (n) @(negedge convert_strobe);
    // frame_active only rises a cycle after the strobe falls
    repeat (2) @(negedge clk_sys);
    run = 1'b0;
    for (int i = 0; i < 3000 && (frame_active !== 1'b0 || exp_q.size() != 0 || result_valid !== 1'b0); i++)
      @(negedge clk_sys);
    check_val("words left", 0, exp_q.size());
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // expectation at each conversion start while the echo is not muted; corner words first, random after
  always @(negedge convert_strobe) if (!reset && !mute) exp_q.push_back(expect_pair(word_one, word_two));
  always @(posedge convert_strobe) begin
    frames++;
    word_one = (frames == 1) ? 16'h7FFF : (frames == 2) ? 16'h0000 : next_rand();
    word_two = (frames == 1) ? 16'hFFFF : (frames == 2) ? 16'h8001 : next_rand();
  end
  // consumer: random readiness when draining, stalled otherwise
  always @(negedge clk_sys) begin
    rnd = next_rand();
    result_ready <= drain && rnd[0];
  end
  always @(posedge clk_sys) begin
    if (!reset && frame_lost === 1'b1)
      lost_seen++;
    if (!reset && result_valid === 1'b1 && result_ready === 1'b1)
      check_val("result pair", (exp_q.size() != 0) ? exp_q.pop_front() : 32'hXXXXXXXX,
                {result_lane_one, result_lane_two});
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    end_of_test();
  end
  initial begin
    {reset, run, capture_on_own_clock, slow, mute} = 5'h10;
    lane_mode = SINGLE_ENDED;
    {drain, mismatches, check_count, frames, lost_seen} = '0;
    seed = 16'h5582;
    word_one = 16'h8000;
    word_two = 16'h7FFF;
    do_reset();
    drain = 1'b1;
    // every lane mode with both capture clocks; echo capture runs slow in DIFFERENTIAL mode only, prompt otherwise
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 2; c++) begin
        @(negedge clk_sys) lane_mode = lane_mode_type'(m);
        capture_on_own_clock = c[0];
        slow = c[0] ^ m[0];
        run_frames(3);
      end
    end
    // idle with run low: strobe stays high, nothing starts
    repeat (100) @(negedge clk_sys);
    check_val("idle strobe", 2'b10, {convert_strobe, frame_active});
    // consumer stalls: buffer fills, conversions stop
    {drain, capture_on_own_clock} = 2'h0;
    run = 1'b1;
    repeat (1600) @(negedge clk_sys);
    stall_mark = frames;
    repeat (300) @(negedge clk_sys);
    check_val("frames while full", stall_mark, frames);
    check_val("words held", `FIFO_DEPTH_WORDS + 1, exp_q.size());
    drain = 1'b1;
    run_frames(1);
    // echo never returns: each frame is lost, nothing delivered
    mute = 1'b1;
    run_frames(2);
    check_val("lost frames", 2, lost_seen);
    mute = 1'b0;
    // reset in mid-frame, then normal frames again
    @(negedge clk_sys) run = 1'b1;
    @(negedge convert_strobe);
    repeat (40) @(negedge clk_sys);
    do_reset();
    run_frames(2);
    end_of_test();
  end
endmodule
